// ==== hw/adcc_pkg.sv ====
// adcc_pkg: register map, field layout, reset values and codes of the converter control.
// assumes a 32-bit AHB-Lite register bus and one peripheral clock.
package adcc_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_ENABLE = 8'h00;
  localparam logic [7:0] ADDR_CONV_CONFIG = 8'h04;
  localparam logic [7:0] ADDR_WINDOW_MODE = 8'h08;
  localparam logic [7:0] ADDR_SW_TRIGGER = 8'h0C;
  localparam logic [7:0] ADDR_INPUT_SEL = 8'h10;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h14;
  localparam logic [7:0] ADDR_CALIBRATION = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h20;
  localparam logic [7:0] ADDR_INT_MASK = 8'h24;
  localparam logic [7:0] ADDR_RESULT = 8'h28;
  localparam logic [7:0] ADDR_WRITE_LOCK = 8'h2C;
  // conversion_config fields
  localparam int CFG_DIFF_BIT = 0;
  localparam int CFG_LEFT_BIT = 1;
  localparam int CFG_CONT_BIT = 2;
  localparam int CFG_CORR_BIT = 3;
  localparam int CFG_RES_LSB = 4;
  localparam int CFG_PRESC_LSB = 8;
  localparam logic [15:0] CFG_WRITABLE = 16'h073F;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [7:0] WIN_WRITABLE = 8'h07;
  localparam logic [7:0] WIN_RESET = 8'h00;
  // software_trigger fields
  localparam int TRIG_FLUSH_BIT = 0;
  localparam int TRIG_START_BIT = 1;
  // status / interrupt bit positions
  localparam int STAT_SYNC_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int IRQ_RESRDY_BIT = 0;
  localparam int IRQ_WINDOW_BIT = 1;
  localparam int IRQ_W = 2;
  // enable register and lock
  localparam int ENABLE_BIT = 1;
  localparam int LOCK_BIT = 0;
  // prescaler: code 0 divides by 2**PRESC_BASE_SHIFT
  localparam int PRESC_BASE_SHIFT = 2;
  // resolution codes
  localparam logic [1:0] RES_12 = 2'h0;
  localparam logic [1:0] RES_16 = 2'h1;
  localparam logic [1:0] RES_10 = 2'h2;
  localparam logic [1:0] RES_8 = 2'h3;
  // window compare codes
  localparam logic [2:0] WIN_OFF = 3'h0;
  localparam logic [2:0] WIN_ABOVE = 3'h1;
  localparam logic [2:0] WIN_BELOW = 3'h2;
  localparam logic [2:0] WIN_INSIDE = 3'h3;
  localparam logic [2:0] WIN_OUTSIDE = 3'h4;
  // gain is unsigned fixed point with this many fraction bits (unity = 1 << GAIN_FRAC)
  localparam int GAIN_FRAC = 11;
  localparam logic [11:0] GAIN_RESET = 12'h800;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CONV = 4'b0010,
    ST_CORR = 4'b0100,
    ST_FLUSH = 4'b1000
  } adcc_state_type;
endpackage

// ==== hw/adcc_prescaler.sv ====
// adcc_prescaler: divides the peripheral clock by a power of two for the converter.
// assumes sel only changes while the converter is disabled; restart re-phases the divider.
`timescale 1ns/1ps
module adcc_prescaler
  import adcc_pkg::*;
#(
  parameter int SEL_W = 3
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic [SEL_W-1:0] sel,
  input wire logic restart,
  // converter clock and its one-cycle tick
  output logic adc_clk_q,
  output logic tick_q
);
  localparam int CNT_W = (1 << SEL_W) + PRESC_BASE_SHIFT;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last;
  logic [CNT_W-1:0] half;

  initial begin
    if (SEL_W < 1 || SEL_W > 4) $error("adcc_prescaler: SEL_W out of range");
  end

  // period is 4 << sel peripheral clocks
  assign last = CNT_W'((1 << (int'(sel) + PRESC_BASE_SHIFT)) - 1);
  assign half = CNT_W'(1 << (int'(sel) + PRESC_BASE_SHIFT - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
      adc_clk_q <= 1'b0;
    end else if (restart) begin
      // flush re-phases the converter clock on this edge
      cnt_q <= '0;
      tick_q <= 1'b0;
      adc_clk_q <= 1'b0;
    end else begin
      cnt_q <= (cnt_q >= last) ? '0 : cnt_q + 1'b1;
      tick_q <= (cnt_q >= last);
      adc_clk_q <= (cnt_q >= half - 1'b1) && (cnt_q < last);
    end
  end
endmodule

// ==== hw/adcc_ctrl.sv ====
// adcc_ctrl: converter control with AHB-Lite register slave, prescaler, sequencing,
// correction, alignment, window compare and interrupt.
// assumes the analog core converts on conv_start and answers with one conv_done pulse.
//
// Summary of operation
// - converter clock is peripheral clock over 4, doubling per code up to 512
// - resolution code picks 12, 16, 10 or 8 bit results
// - correction enable applies gain and offset and adds offset-derived extra cycles
// - continuous mode restarts after each completion; otherwise single conversions
// - left align puts the result high byte in the upper register part
// - differential mode converts positive minus negative input
// - window mode 0 off, 1 above lower, 2 below upper threshold
// - mode 3 strictly between thresholds, 4 not between, 5 to 7 reserved
// - writing one to start launches a conversion; hardware clears it on start
// - flush restarts converter clock next edge and aborts running conversion
// - flush bit reads set until the flush completes, then clears
// - after flush, a pending conversion starts again
// - reserved bits read zero; software writes them zero
// - control, window and trigger writes are write-protected and synchronized
// - sync pending status stays set while a synchronized write is in flight
// - negative input has its own selection field beside the positive one
`timescale 1ns/1ps
module adcc_ctrl
  import adcc_pkg::*;
#(
  parameter int RES_W = 16
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // analog core
  input wire logic conv_done,
  input wire logic [RES_W-1:0] raw_result,
  output logic adc_clk,
  output logic conv_start,
  output logic conv_abort,
  output logic [1:0] resolution_select,
  output logic differential_enable,
  output logic [4:0] positive_input_select,
  output logic [4:0] negative_input_select,
  // results and interrupt
  output logic [RES_W-1:0] result,
  output logic result_valid,
  output logic window_hit,
  output logic irq
);
  initial begin
    if (RES_W != 16) $error("adcc_ctrl: RES_W must be 16");
  end
  // bus-side registers
  logic enable_q, lock_q;
  logic [15:0] cfg_q, act_cfg_q;
  logic [2:0] win_q, act_win_q;
  logic start_q, flush_q;
  logic [4:0] pos_q, neg_q;
  logic [15:0] lower_q, upper_q;
  logic [11:0] gain_q, offset_q;
  logic [IRQ_W-1:0] int_stat_q, int_mask_q, int_set;
  logic sync_q;
  // data phase
  logic dph_wr_q;
  logic [7:0] dph_addr_q;
  // sequencing
  adcc_state_type state_q;
  logic rerun_q, flush_go_q;
  logic [3:0] extra_q;
  logic [15:0] corr_val_q;
  logic tick, adc_clk_w;
  wire addr_take = hsel && hready && htrans[1];
  wire wr_en = dph_wr_q;
  wire prot_ok = !lock_q;
  wire wr_cfg = wr_en && prot_ok && (dph_addr_q == ADDR_CONV_CONFIG);
  wire wr_win = wr_en && prot_ok && (dph_addr_q == ADDR_WINDOW_MODE);
  wire wr_trig = wr_en && prot_ok && (dph_addr_q == ADDR_SW_TRIGGER);
  wire busy = (state_q == ST_CONV) || (state_q == ST_CORR);
  adcc_prescaler #(
    .SEL_W(3)
  ) u_presc (
    .hclk(hclk),
    .hresetn(hresetn),
    .sel(act_cfg_q[CFG_PRESC_LSB +: 3]),
    .restart(flush_go_q),
    .adc_clk_q(adc_clk_w),
    .tick_q(tick)
  );
  // read mux; reserved bits come back zero
  function automatic logic [31:0] read_word(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      ADDR_ENABLE: v[ENABLE_BIT] = enable_q;
      ADDR_CONV_CONFIG: v[15:0] = cfg_q & CFG_WRITABLE;
      ADDR_WINDOW_MODE: v[2:0] = win_q;
      ADDR_SW_TRIGGER: v[1:0] = {start_q, flush_q};
      ADDR_INPUT_SEL: v = {19'h0, neg_q, 3'h0, pos_q};
      ADDR_THRESHOLD: v = {upper_q, lower_q};
      ADDR_CALIBRATION: v = {4'h0, gain_q, 4'h0, offset_q};
      ADDR_STATUS: v[1:0] = {busy, sync_q};
      ADDR_INT_STATUS: v[IRQ_W-1:0] = int_stat_q;
      ADDR_INT_MASK: v[IRQ_W-1:0] = int_mask_q;
      ADDR_RESULT: v[15:0] = result;
      ADDR_WRITE_LOCK: v[LOCK_BIT] = lock_q;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction
  // bus slave: zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr_q <= 1'b0;
      dph_addr_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      dph_wr_q <= addr_take && hwrite;
      if (addr_take) begin
        dph_addr_q <= {haddr[7:2], 2'b00};
        hrdata <= hwrite ? 32'h0000_0000 : read_word({haddr[7:2], 2'b00});
      end
    end
  end
  // plain control registers, protected by the lock except the lock itself
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enable_q <= 1'b0;
      lock_q <= 1'b0;
      pos_q <= 5'h00;
      neg_q <= 5'h00;
      lower_q <= 16'h0000;
      upper_q <= 16'h0000;
      gain_q <= GAIN_RESET;
      offset_q <= 12'h000;
      int_mask_q <= '0;
    end else if (wr_en) begin
      if (dph_addr_q == ADDR_WRITE_LOCK) lock_q <= hwdata[LOCK_BIT];
      if (prot_ok) begin
        case (dph_addr_q)
          ADDR_ENABLE: enable_q <= hwdata[ENABLE_BIT];
          ADDR_INPUT_SEL: begin
            pos_q <= hwdata[4:0];
            neg_q <= hwdata[12:8];
          end
          ADDR_THRESHOLD: begin
            lower_q <= hwdata[15:0];
            upper_q <= hwdata[31:16];
          end
          ADDR_CALIBRATION: begin
            offset_q <= hwdata[11:0];
            gain_q <= hwdata[27:16];
          end
          ADDR_INT_MASK: int_mask_q <= hwdata[IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end
  // config is frozen while enabled; disabled writes apply
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_q <= CFG_RESET;
      win_q <= 3'h0;
    end else begin
      if (wr_cfg && !enable_q) cfg_q <= hwdata[15:0] & CFG_WRITABLE;
      if (wr_win) win_q <= hwdata[2:0] & WIN_WRITABLE[2:0];
    end
  end
  // writes reach the converter side on the next converter clock tick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_q <= 1'b0;
      act_cfg_q <= CFG_RESET;
      act_win_q <= 3'h0;
    end else begin
      if (tick) begin
        act_cfg_q <= cfg_q;
        act_win_q <= win_q;
      end
      // a write landing on the tick keeps the flag up
      if (wr_cfg || wr_win || wr_trig) sync_q <= 1'b1;
      else if (tick) sync_q <= 1'b0;
    end
  end
  // start: set by writing one, cleared when the conversion starts
  wire launch = tick && enable_q && (state_q == ST_IDLE) && !flush_q && (start_q || rerun_q);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_q <= 1'b0;
    end else if (wr_trig && hwdata[TRIG_START_BIT]) begin
      start_q <= 1'b1; // writing one over one changes nothing
    end else if (launch || !enable_q) begin
      start_q <= 1'b0;
    end
  end
  // flush bit stays set until the flush has run through
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flush_q <= 1'b0;
      flush_go_q <= 1'b0;
    end else begin
      flush_go_q <= wr_trig && hwdata[TRIG_FLUSH_BIT] && !flush_q;
      if (wr_trig && hwdata[TRIG_FLUSH_BIT]) flush_q <= 1'b1;
      else if (state_q == ST_FLUSH && tick) flush_q <= 1'b0;
    end
  end
  // gain and offset correction on the 12-bit value, saturated
  function automatic logic [11:0] correct(input logic [11:0] raw, input logic [11:0] off,
                                          input logic [11:0] gain);
    logic signed [13:0] diff;
    logic signed [27:0] prod;
    logic signed [27:0] scaled;
    diff = $signed({2'b00, raw}) - $signed({{2{off[11]}}, off});
    prod = 28'(diff) * $signed({16'h0000, gain});
    scaled = prod >>> GAIN_FRAC;
    if (scaled < 0) return 12'h000;
    if (scaled > 28'sd4095) return 12'hFFF;
    return scaled[11:0];
  endfunction
  // place the value by resolution and alignment
  function automatic logic [15:0] place(input logic [15:0] v, input logic [1:0] res,
                                        input logic left);
    logic [15:0] r;
    case (res)
      RES_12: r = left ? {v[11:0], 4'h0} : {4'h0, v[11:0]};
      RES_10: r = left ? {v[9:0], 6'h00} : {6'h00, v[9:0]};
      RES_8: r = left ? {v[7:0], 8'h00} : {8'h00, v[7:0]};
      RES_16: r = v;
      default: r = v;
    endcase
    return r;
  endfunction
  // window compare on the right-aligned value
  function automatic logic win_check(input logic [2:0] mode, input logic [15:0] v,
                                     input logic [15:0] lo, input logic [15:0] hi);
    logic w;
    case (mode)
      WIN_ABOVE: w = v > lo;
      WIN_BELOW: w = v < hi;
      WIN_INSIDE: w = (v > lo) && (v < hi);
      WIN_OUTSIDE: w = !((v > lo) && (v < hi));
      default: w = 1'b0; // off and reserved codes never flag
    endcase
    return w;
  endfunction
  wire corr_on = act_cfg_q[CFG_CORR_BIT];
  wire [1:0] act_res = act_cfg_q[CFG_RES_LSB +: 2];
  wire [15:0] raw_fix = corr_on ? {raw_result[15:12], correct(raw_result[11:0], offset_q,
                                   gain_q)} : raw_result;
  // whole word held: the core's upper bits are gone by the end of the extra cycles
  wire [15:0] corr_fix = corr_val_q;
  wire finish_now = (state_q == ST_CONV) && conv_done && !(corr_on && offset_q[3:0] != 4'h0);
  wire finish_corr = (state_q == ST_CORR) && tick && (extra_q == 4'h1);
  wire [15:0] fin_val = finish_corr ? corr_fix : raw_fix;
  // sequencer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      rerun_q <= 1'b0;
      extra_q <= 4'h0;
      corr_val_q <= 16'h0000;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (flush_go_q) begin
            state_q <= ST_FLUSH;
          end else if (launch) begin
            conv_start <= 1'b1;
            rerun_q <= 1'b0;
            state_q <= ST_CONV;
          end
        end
        ST_CONV, ST_CORR: begin
          if (flush_go_q || !enable_q) begin
            // disable loses the running conversion; flush marks it to run again
            conv_abort <= 1'b1;
            rerun_q <= flush_go_q;
            state_q <= flush_go_q ? ST_FLUSH : ST_IDLE;
          end else if (state_q == ST_CONV && conv_done) begin
            if (corr_on && offset_q[3:0] != 4'h0) begin
              // extra converter clocks for correction
              extra_q <= offset_q[3:0];
              corr_val_q <= raw_fix;
              state_q <= ST_CORR;
            end else begin
              rerun_q <= act_cfg_q[CFG_CONT_BIT];
              state_q <= ST_IDLE;
            end
          end else if (state_q == ST_CORR && tick) begin
            extra_q <= extra_q - 4'h1;
            if (extra_q == 4'h1) begin
              rerun_q <= act_cfg_q[CFG_CONT_BIT];
              state_q <= ST_IDLE;
            end
          end
        end
        ST_FLUSH: begin
          // back to idle once the clock has restarted; an aborted or pending conversion starts again from scratch
          if (tick) begin
            rerun_q <= rerun_q || start_q;
            state_q <= ST_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
  // result register and events
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result <= 16'h0000;
      result_valid <= 1'b0;
      window_hit <= 1'b0;
    end else begin
      result_valid <= 1'b0;
      window_hit <= 1'b0;
      if (enable_q && !flush_go_q && (finish_now || finish_corr)) begin
        result <= place(fin_val, act_res, act_cfg_q[CFG_LEFT_BIT]);
        result_valid <= 1'b1;
        window_hit <= win_check(act_win_q, place(fin_val, act_res, 1'b0), lower_q, upper_q);
      end
    end
  end
  // sticky interrupt status: write one clears, a new event wins
  assign int_set = {window_hit, result_valid};
  wire wr_int_clr = wr_en && (dph_addr_q == ADDR_INT_STATUS);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_q <= '0;
      irq <= 1'b0;
    end else begin
      int_stat_q <= (int_stat_q & ~(wr_int_clr ? hwdata[IRQ_W-1:0] : '0)) | int_set;
      irq <= |(((int_stat_q & ~(wr_int_clr ? hwdata[IRQ_W-1:0] : '0)) | int_set) & int_mask_q);
    end
  end
  // converter-facing configuration, registered copies
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adc_clk <= 1'b0;
      resolution_select <= RES_12;
      differential_enable <= 1'b0;
      positive_input_select <= 5'h00;
      negative_input_select <= 5'h00;
    end else begin
      adc_clk <= adc_clk_w;
      resolution_select <= act_res;
      differential_enable <= act_cfg_q[CFG_DIFF_BIT];
      positive_input_select <= pos_q;
      negative_input_select <= neg_q;
    end
  end
endmodule

// ==== dv/adcc_ctrl_monitor.sv ====
// adcc_ctrl_monitor: port-level assertions for the converter control block.
// assumes it is bound into adcc_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module adcc_ctrl_chk
  import adcc_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // converter side
  input wire logic adc_clk,
  input wire logic conv_start,
  input wire logic conv_abort,
  input wire logic result_valid,
  input wire logic window_hit
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // a flush write may cut the running converter clock phase short
  logic [3:0] trig_q;
  always_ff @(posedge hclk) begin
    trig_q <= {trig_q[2:0], hsel && hready && htrans[1] && hwrite &&
               haddr[7:0] == ADDR_SW_TRIGGER};
  end
  sequence s_rd(logic [7:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr == {24'h0, a};
  endsequence
  // shortest half period is two cycles, since the smallest divide is four
  sequence s_hold_hi;
    adc_clk ##1 adc_clk;
  endsequence
  sequence s_hold_lo;
    !adc_clk ##1 !adc_clk;
  endsequence
  property p_ready; hreadyout; endproperty
  property p_okay; !hresp; endproperty
  property p_cfg_rsv; s_rd(ADDR_CONV_CONFIG) |=> hrdata[31:11] == 21'h0; endproperty
  property p_win_rsv; s_rd(ADDR_WINDOW_MODE) |=> hrdata[31:3] == 29'h0; endproperty
  property p_trig_rsv; s_rd(ADDR_SW_TRIGGER) |=> hrdata[31:2] == 30'h0; endproperty
  property p_start_pulse; conv_start |=> !conv_start; endproperty
  property p_hit_valid; window_hit |-> result_valid; endproperty
  property p_abort; conv_abort |-> !conv_start ##1 !conv_abort; endproperty
  property p_clk_high; $rose(adc_clk) && trig_q == 4'h0 |-> s_hold_hi; endproperty
  property p_clk_low; $fell(adc_clk) |-> s_hold_lo; endproperty
  a_ready: assert property (p_ready) else $error("ready dropped");
  a_okay: assert property (p_okay) else $error("error response seen");
  a_cfg_rsv: assert property (p_cfg_rsv) else $error("config reserved set");
  a_win_rsv: assert property (p_win_rsv) else $error("window reserved set");
  a_trig_rsv: assert property (p_trig_rsv) else $error("trigger reserved set");
  a_start_pulse: assert property (p_start_pulse) else $error("start too long");
  a_hit_valid: assert property (p_hit_valid) else $error("hit without result");
  a_abort: assert property (p_abort) else $error("abort with start");
  a_clk_high: assert property (p_clk_high) else $error("clock high too short");
  a_clk_low: assert property (p_clk_low) else $error("clock low too short");
endmodule
bind adcc_ctrl adcc_ctrl_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .adc_clk(adc_clk), .conv_start(conv_start),
  .conv_abort(conv_abort), .result_valid(result_valid), .window_hit(window_hit));

// ==== dv/adcc_core_model.sv ====
// adcc_core_model: behavioural analog core answering each conversion start that is not aborted.
// assumes one-cycle start and abort pulses from the control block.
`timescale 1ns/1ps
module adcc_core_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic conv_start,
  input wire logic conv_abort,
  // bench settings
  input wire logic [15:0] sample,
  input wire logic [9:0] lat,
  // answer
  output logic conv_done,
  output logic [15:0] raw_result
);
  int cnt;
  // junk outside the done pulse so a late capture shows up
  assign raw_result = conv_done ? sample : ~sample;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (conv_abort) begin
        cnt <= 0;
      end else if (conv_start) begin
        cnt <= lat;
      end else if (cnt == 1) begin
        cnt <= 0;
        conv_done <= 1'b1;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ==== dv/tb_top.sv ====
// tb_top: register-level bench for the converter control with a behavioural core.
// assumes zero-wait AHB-Lite answers and a 250 MHz peripheral clock.
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin err_total++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module tb_top;
  import adcc_pkg::*;
  localparam logic [15:0] LO = 16'h0100;
  localparam logic [15:0] HI = 16'h0800;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [15:0] sample = 16'h0, raw_result, result, r, v;
  logic [9:0] lat = 10'h1;
  logic hready, hresp, conv_done, adc_clk, conv_start, conv_abort, differential_enable;
  logic result_valid, window_hit, irq, h;
  logic [1:0] resolution_select;
  logic [4:0] positive_input_select, negative_input_select;
  int err_total = 0, total_checks = 0, cyc = 0, n_start = 0, n_abort = 0, n_valid = 0;
  int s0, a0;
  time t0;
  always #2 hclk = ~hclk;
  adcc_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .conv_done(conv_done), .raw_result(raw_result),
    .adc_clk(adc_clk), .conv_start(conv_start), .conv_abort(conv_abort),
    .resolution_select(resolution_select), .differential_enable(differential_enable),
    .positive_input_select(positive_input_select), .negative_input_select(negative_input_select),
    .result(result), .result_valid(result_valid), .window_hit(window_hit), .irq(irq));
  adcc_core_model u_core (.hclk(hclk), .hresetn(hresetn), .conv_start(conv_start),
    .conv_abort(conv_abort), .sample(sample), .lat(lat), .conv_done(conv_done),
    .raw_result(raw_result));
  always @(posedge hclk) begin
    cyc++;
    n_start += (conv_start === 1'b1);
    n_abort += (conv_abort === 1'b1);
    n_valid += (result_valid === 1'b1);
    if (cyc == 20000) begin
      err_total++;
      $display("BAD %0t timeout", $time);
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    `CHK(x, e)
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge hclk);
  endtask
  task automatic wait_valid();
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (result_valid !== 1'b1 && n < 2000);
    if (n == 2000) begin
      err_total++;
      $display("BAD %0t no result", $time);
    end
    r = result;
    h = window_hit;
  endtask
  task automatic convert(input logic [15:0] s);
    @(posedge hclk);
    sample <= s;
    wr(ADDR_SW_TRIGGER, 32'h2);
    wait_valid();
  endtask
  // config is only legal while disabled, so every change after the first enable goes through here
  task automatic reconfig(input logic [31:0] c);
    wr(ADDR_ENABLE, 32'h0);
    idle(40);
    wr(ADDR_CONV_CONFIG, c);
    idle(40);
    wr(ADDR_ENABLE, 32'h2);
    idle(80);
  endtask
  function automatic logic win(input logic [2:0] m, input logic [15:0] x);
    case (m)
      3'h1: return x > LO;
      3'h2: return x < HI;
      3'h3: return x > LO && x < HI;
      3'h4: return !(x > LO && x < HI);
      default: return 1'b0;
    endcase
  endfunction
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(ADDR_CONV_CONFIG, 32'h0);
    rd_chk(ADDR_WINDOW_MODE, 32'h0);
    rd_chk(ADDR_SW_TRIGGER, 32'h0);
    rd_chk(8'h3C, 32'h0);
    wr(ADDR_CONV_CONFIG, 32'hFFFF_FFFF);
    rd_chk(ADDR_CONV_CONFIG, 32'h0000_073F);
    wr(ADDR_WINDOW_MODE, 32'hFFFF_FFFF);
    rd_chk(ADDR_WINDOW_MODE, 32'h0000_0007);
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CONV_CONFIG, (c << 8) | ((c & 3) << 4) | (c & 1));
      if (c == 0) rd_chk(ADDR_STATUS, 32'h1);
      repeat (3) @(posedge adc_clk);
      t0 = $time;
      @(posedge adc_clk);
      `CHK(int'(($time - t0) / 4), 4 << c)
      `CHK(resolution_select, 2'(c))
      `CHK(differential_enable, 1'(c))
    end
    rd_chk(ADDR_STATUS, 32'h0);
    wr(ADDR_CONV_CONFIG, 32'h0);
    wr(ADDR_THRESHOLD, {HI, LO});
    wr(ADDR_INT_MASK, 32'h2);
    wr(ADDR_INPUT_SEL, 32'h0000_031A);
    idle(600);
    wr(ADDR_ENABLE, 32'h2);
    wr(ADDR_CONV_CONFIG, 32'h0000_0412);
    rd_chk(ADDR_CONV_CONFIG, 32'h0);
    wr(ADDR_WRITE_LOCK, 32'h1);
    wr(ADDR_WINDOW_MODE, 32'h3);
    rd_chk(ADDR_WINDOW_MODE, 32'h7);
    wr(ADDR_WRITE_LOCK, 32'h0);
    `CHK(positive_input_select, 5'h1A)
    `CHK(negative_input_select, 5'h03)
    s0 = n_start;
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_WINDOW_MODE, m);
      for (int k = 0; k < 3; k++) begin
        v = k == 0 ? LO : k == 1 ? 16'h0400 : HI;
        convert(v);
        `CHK(r, v)
        `CHK(h, win(3'(m), v))
        idle(2);
        `CHK(irq, h)
        rd_chk(ADDR_INT_STATUS, {30'h0, h, 1'b1});
        wr(ADDR_INT_STATUS, 32'h3);
        idle(2);
        `CHK(irq, 1'b0)
      end
    end
    `CHK(n_start - s0, 24)
    rd_chk(ADDR_SW_TRIGGER, 32'h0);
    reconfig(32'h0000_0300);
    @(posedge hclk);
    lat <= 10'd200;
    wr(ADDR_SW_TRIGGER, 32'h2);
    idle(80);
    a0 = n_abort;
    s0 = n_start;
    wr(ADDR_SW_TRIGGER, 32'h1);
    rd_chk(ADDR_SW_TRIGGER, 32'h1);
    lat <= 10'd1;
    wait_valid();
    `CHK(n_abort - a0, 1)
    `CHK(n_start - s0, 1)
    rd_chk(ADDR_SW_TRIGGER, 32'h0);
    reconfig(32'h0000_0002);
    convert(16'h0ABC);
    `CHK(r, 16'hABC0)
    reconfig(32'h0000_0032);
    convert(16'h00AB);
    `CHK(r, 16'hAB00)
    wr(ADDR_CALIBRATION, 32'h0400_0002);
    reconfig(32'h0000_0018);
    convert(16'h5402);
    `CHK(r, 16'h5200)
    reconfig(32'h0000_0004);
    s0 = n_valid;
    wr(ADDR_SW_TRIGGER, 32'h2);
    idle(200);
    `CHK(n_valid - s0 > 3, 1'b1)
    wr(ADDR_ENABLE, 32'h0);
    idle(40);
    s0 = n_valid;
    idle(200);
    `CHK(n_valid - s0, 0)
    tally_and_finish();
  end
endmodule
